/* hw/mrs_pkg.sv */
// shared constants for the readback port and its bus master
package mrs_pkg;
   localparam int CLK_KHZ      = 125000;                    // system clock rate
   localparam int SCL_KHZ      = 400;                       // fastest allowed serial clock
   localparam int QTR_CYC      = (CLK_KHZ + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ); // quarter bit, rounded up
   localparam int ADC_W        = 12;                        // conversion result width
   localparam int OC_RUN       = 3;                         // over-threshold conversions in a row
   // status byte field positions
   localparam int ST_DIG_OC    = 0;
   localparam int ST_DIG_ALERT = 1;
   localparam int ST_ANA_OFF   = 2;
   localparam int ST_FAIL      = 3;
   localparam int ST_OFF       = 4;
   localparam int ST_OFF_ALERT = 5;
   localparam logic [7:0] STATUS_RST = 8'h00;               // status byte after reset
   localparam logic [7:0] IDLE_BYTE  = 8'hFF;               // released line past the payload
   // host register map, byte addresses
   localparam logic [7:0] REG_CMD  = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_DATA = 8'h08;
   localparam int CMD_ADDR_LSB = 0;                         // 7-bit slave address
   localparam int CMD_LEN_LSB  = 8;                         // 2-bit byte count
   localparam int CMD_GO       = 16;                        // start a read
   localparam int STAT_BUSY    = 0;
   localparam int STAT_NACK    = 1;
   localparam logic [31:0] DATA_RST = 32'h0000_0000;
   // payload shape chosen at address acknowledge
   typedef enum logic [1:0] {MODE_BOTH, MODE_VOLT, MODE_AMP, MODE_STATUS} mrs_mode_t;
endpackage

/* hw/mrs_i2c_if.sv */
`timescale 1ns/10ps
`default_nettype none
// open-drain serial pair; an enable high pulls the wire low
interface mrs_i2c_if;
   logic sclOut;   // host clock level when driving
   logic sclOe;    // host pulls clock
   logic hSdaOut;  // host data level when driving
   logic hSdaOe;   // host pulls data
   logic dSdaOut;  // device data level when driving
   logic dSdaOe;   // device pulls data
   wire  scl;      // resolved clock wire
   wire  sda;      // resolved data wire
   // wired-and with pull-up
   assign scl = ~(sclOe & ~sclOut);
   assign sda = ~((hSdaOe & ~hSdaOut) | (dSdaOe & ~dSdaOut));
   modport host (output sclOut, sclOe, hSdaOut, hSdaOe, input scl, sda);
   modport dev  (output dSdaOut, dSdaOe, input scl, sda);
endinterface
`default_nettype wire

/* hw/mrs_dev_end.sv */
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - payload follows configured conversion channels
// - both channels: V high, I high, packed lows
// - voltage only: V high, V low nibble
// - current only: I high, I low nibble
// - start, address with read, ack, data
// - master acks two bytes, nacks third, stops
// - single channel: master reads two bytes
// - status read returns one status byte
// - bit0: three conversions over threshold
// - bit1: sticky digital overcurrent alert
// - bit2: switch off from analog trip; with LATCH_OFF set, the enabled failure flag
// - bit3: sticky switch failure flag
// - bit4: on input low or forced off
// - bit5: sticky turn-off alert
// - clear removes bits 1, 3, 5
// - results are unsigned twelve-bit codes
// - status-read bit returns status byte
// - nack reads while single conversion pending
// - continuous mode before first result: zeros
// - clear control self-clears on the same edge that clears the flags
module mrs_dev_end #(
   parameter bit LATCH_OFF = 1'b1                           // latch-off variant when set
) (
   input  wire  logic                    clk,
   input  wire  logic                    rst_n,
   mrs_i2c_if.dev                        bus,
   input  wire  logic [6:0]              devAddr,            // own 7-bit address
   input  wire  logic [mrs_pkg::ADC_W-1:0] voltCode,         // voltage result
   input  wire  logic                    voltDone,           // voltage result ready, pulse
   input  wire  logic [mrs_pkg::ADC_W-1:0] ampCode,          // current result
   input  wire  logic                    ampDone,            // current result ready, pulse
   input  wire  logic                    ampOver,            // current over threshold, with ampDone
   input  wire  logic                    voltSelect,         // voltage channel configured
   input  wire  logic                    ampSelect,          // current channel configured
   input  wire  logic                    voltOnceReq,        // single voltage conversion, pulse
   input  wire  logic                    ampOnceReq,         // single current conversion, pulse
   input  wire  logic                    statusRead,         // read returns status byte
   input  wire  logic                    digTripEvt,         // digital trip raised alert, pulse
   input  wire  logic                    analog_trip_off_state, // switch off by analog trip
   input  wire  logic                    switchFailEvt,      // hot swap failed, pulse
   input  wire  logic                    switch_fail_enable, // alert enable for failures
   input  wire  logic                    offAlertEnable,     // alert enable for turn-off
   input  wire  logic                    onCtl,              // on-control input, high is on
   input  wire  logic                    software_force_off, // software force-off bit
   input  wire  logic                    clearReq,           // clear written, pulse
   output logic [7:0]                    statusByte,         // live status byte
   output logic                          voltOncePend,       // single voltage request open
   output logic                          ampOncePend,        // single current request open
   output logic                          clearBusy           // clear control bit state
);
   import mrs_pkg::*;

   typedef enum logic [2:0] {D_IDLE, D_ADDR, D_AACK, D_SEND, D_MACK, D_NEXT} mrs_dst_t;

   typedef struct packed {
      mrs_dst_t         st;       // slave sequencer state
      logic             sclQ;     // last clock sample
      logic             sdaQ;     // last data sample
      logic [3:0]       cnt;      // bit counter
      logic [7:0]       sh;       // shift register
      logic [1:0]       idx;      // byte index in payload
      mrs_mode_t        mode;     // payload shape of this read
      logic [ADC_W-1:0] vSnap;    // voltage held for this read
      logic [ADC_W-1:0] iSnap;    // current held for this read
      logic [7:0]       sSnap;    // status held for this read
      logic             sdaOe;    // pulling data low
      logic [ADC_W-1:0] vData;    // latest voltage result
      logic [ADC_W-1:0] iData;    // latest current result
      logic             vPend;    // single voltage request open
      logic             iPend;    // single current request open
      logic [OC_RUN-1:0] ocHist;  // recent over-threshold history
      logic             digAlert; // sticky digital alert
      logic             fail;     // sticky switch failure
      logic             offAlert; // sticky turn-off alert
      logic             offQ;     // last off state
      logic             clrBusy;  // clear pending
      logic [7:0]       status;   // status byte register
   } mrs_dev_t;

   mrs_dev_t s;     // current state
   mrs_dev_t nxt_s; // next state

   // byte n of the payload for the given shape; past its end the line is released
   function automatic logic [7:0] pickByte(mrs_mode_t m, logic [1:0] n,
                                           logic [ADC_W-1:0] v, logic [ADC_W-1:0] i, logic [7:0] st);
      logic [7:0] b;
      b = IDLE_BYTE;
      unique case (m)
         MODE_STATUS: if (n == 2'd0) b = st;
         MODE_VOLT: begin
            if (n == 2'd0) b = v[11:4];
            else if (n == 2'd1) b = {v[3:0], 4'h0};
         end
         MODE_AMP: begin
            if (n == 2'd0) b = i[11:4];
            else if (n == 2'd1) b = {i[3:0], 4'h0};
         end
         MODE_BOTH: begin
            if (n == 2'd0) b = v[11:4];
            else if (n == 2'd1) b = i[11:4];
            else if (n == 2'd2) b = {v[3:0], i[3:0]};
         end
      endcase
      return b;
   endfunction

   logic sclRise; // clock rose
   logic sclFall; // clock fell
   logic startC;  // start condition
   logic stopC;   // stop condition
   assign sclRise = bus.scl & ~s.sclQ;
   assign sclFall = ~bus.scl & s.sclQ;
   assign startC  = s.sclQ & bus.scl & s.sdaQ & ~bus.sda;
   assign stopC   = s.sclQ & bus.scl & ~s.sdaQ & bus.sda;

   // next-state logic for the status flags, results and slave sequencer
   always_comb begin
      logic [7:0] nb;  // byte to load
      logic       off; // switch held off
      nb    = IDLE_BYTE;
      nxt_s = s;
      nxt_s.sclQ = bus.scl;
      nxt_s.sdaQ = bus.sda;
      off = ~onCtl | software_force_off;
      nxt_s.offQ = off;

      // results are kept as raw codes; zero until the first conversion ends
      if (voltDone) nxt_s.vData = voltCode;
      if (ampDone) nxt_s.iData = ampCode;
      // single requests stay open until their conversion ends
      if (voltOnceReq) nxt_s.vPend = 1'b1;
      else if (voltDone) nxt_s.vPend = 1'b0;
      if (ampOnceReq) nxt_s.iPend = 1'b1;
      else if (ampDone) nxt_s.iPend = 1'b0;
      if (ampDone) nxt_s.ocHist = {s.ocHist[OC_RUN-2:0], ampOver};

      // sticky flags: clear first, a fresh event in the same cycle wins
      if (s.clrBusy) begin
         nxt_s.digAlert = 1'b0;
         nxt_s.fail     = 1'b0;
         nxt_s.offAlert = 1'b0;
      end
      if (digTripEvt) nxt_s.digAlert = 1'b1;
      if (switchFailEvt && switch_fail_enable) nxt_s.fail = 1'b1;
      if (off && !s.offQ && offAlertEnable) nxt_s.offAlert = 1'b1;
      // clear control drops on the same clock edge that clears the flags
      if (clearReq) nxt_s.clrBusy = 1'b1;
      else if (s.clrBusy) nxt_s.clrBusy = 1'b0;

      nxt_s.status = {2'b00,
                      s.offAlert,
                      off,
                      s.fail,
                      LATCH_OFF ? (s.fail & switch_fail_enable)
                                : analog_trip_off_state,
                      s.digAlert,
                      &s.ocHist};

      // slave sequencer; start and stop override every state
      if (startC) begin
         nxt_s.st    = D_ADDR;
         nxt_s.cnt   = 4'd0;
         nxt_s.sdaOe = 1'b0;
      end else if (stopC) begin
         nxt_s.st    = D_IDLE;
         nxt_s.sdaOe = 1'b0;
      end else begin
         unique case (s.st)
            D_IDLE: ;
            // shift in address and direction bit
            D_ADDR: begin
               if (sclRise) begin
                  nxt_s.sh  = {s.sh[6:0], bus.sda};
                  nxt_s.cnt = s.cnt + 4'd1;
               end else if (sclFall && s.cnt == 4'd8) begin
                  // acknowledge only a read of our address with no single request open
                  if (s.sh[7:1] == devAddr && s.sh[0] && !(s.vPend || s.iPend)) begin
                     nxt_s.st    = D_AACK;
                     nxt_s.sdaOe = 1'b1;
                     nxt_s.vSnap = s.vData;
                     nxt_s.iSnap = s.iData;
                     nxt_s.sSnap = s.status;
                     if (statusRead) nxt_s.mode = MODE_STATUS;
                     else if (voltSelect && ampSelect) nxt_s.mode = MODE_BOTH;
                     else if (ampSelect) nxt_s.mode = MODE_AMP;
                     else nxt_s.mode = MODE_VOLT;
                  end else begin
                     nxt_s.st = D_IDLE;
                  end
               end
            end
            // after the acknowledge clock, drive the first byte
            D_AACK: begin
               if (sclFall) begin
                  nb          = pickByte(s.mode, 2'd0, s.vSnap, s.iSnap, s.sSnap);
                  nxt_s.st    = D_SEND;
                  nxt_s.sh    = nb;
                  nxt_s.sdaOe = ~nb[7];
                  nxt_s.cnt   = 4'd0;
                  nxt_s.idx   = 2'd0;
               end
            end
            // eight data bits, changed only while the clock is low
            D_SEND: begin
               if (sclRise) begin
                  nxt_s.cnt = s.cnt + 4'd1;
               end else if (sclFall) begin
                  if (s.cnt == 4'd8) begin
                     nxt_s.st    = D_MACK;
                     nxt_s.sdaOe = 1'b0;
                  end else begin
                     nxt_s.sh    = {s.sh[6:0], 1'b1};
                     nxt_s.sdaOe = ~s.sh[6];
                  end
               end
            end
            // master acknowledge asks for more, a nack ends our part
            D_MACK: begin
               if (sclRise) nxt_s.st = bus.sda ? D_IDLE : D_NEXT;
            end
            D_NEXT: begin
               if (sclFall) begin
                  nb          = pickByte(s.mode, s.idx + 2'd1, s.vSnap, s.iSnap, s.sSnap);
                  nxt_s.st    = D_SEND;
                  nxt_s.idx   = s.idx + 2'd1;
                  nxt_s.sh    = nb;
                  nxt_s.sdaOe = ~nb[7];
                  nxt_s.cnt   = 4'd0;
               end
            end
         endcase
      end
   end

   // state register with synchronous reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '0;
         s.sclQ <= 1'b1;
         s.sdaQ <= 1'b1;
         s.offQ <= 1'b1;
         s.status <= STATUS_RST;
      end else begin
         s <= nxt_s;
      end
   end

   assign bus.dSdaOut  = 1'b0;
   assign bus.dSdaOe   = s.sdaOe;
   assign statusByte   = s.status;
   assign voltOncePend = s.vPend;
   assign ampOncePend  = s.iPend;
   assign clearBusy    = s.clrBusy;
endmodule // mrs_dev_end
`default_nettype wire

/* hw/mrs_host_end.sv */
`timescale 1ns/10ps
`default_nettype none
// bus master that reads the monitor, ordered over AHB-Lite
module mrs_host_end #(
   parameter int QTR = mrs_pkg::QTR_CYC                     // clocks per quarter bit
) (
   input  wire  logic        clk,
   input  wire  logic        rst_n,
   mrs_i2c_if.host           bus,
   input  wire  logic        hsel,
   input  wire  logic [31:0] haddr,
   input  wire  logic [1:0]  htrans,
   input  wire  logic        hwrite,
   input  wire  logic [2:0]  hsize,
   input  wire  logic [31:0] hwdata,
   input  wire  logic        hready,
   output logic              hreadyout,
   output logic              hresp,
   output logic [31:0]       hrdata
);
   import mrs_pkg::*;

   typedef enum logic [2:0] {H_IDLE, H_START, H_ADDR, H_DATA, H_STOP} mrs_hst_t;

   typedef struct packed {
      mrs_hst_t    st;     // sequencer state
      logic [7:0]  div;    // quarter-bit divider
      logic [1:0]  q;      // quarter within a bit
      logic [3:0]  cnt;    // bit slot in a byte
      logic [7:0]  sh;     // shift register
      logic [1:0]  left;   // bytes still to read
      logic [6:0]  addr;   // target address
      logic [31:0] data;   // bytes read, first byte highest
      logic        busy;   // transfer running
      logic        nack;   // address not acknowledged
      logic        sclLow; // pulling clock low
      logic        sdaLow; // pulling data low
      logic        wrPend; // write data phase follows
      logic [7:0]  wrAddr; // address of that write
      logic [31:0] rdata;  // read data for the data phase
      logic        rdy;    // slave ready
   } mrs_host_t;

   mrs_host_t s;     // current state
   mrs_host_t nxt_s; // next state

   logic tick;  // quarter-bit enable
   logic ahbGo; // valid address phase
   assign tick  = (s.div == 8'(QTR - 1));
   assign ahbGo = hsel & htrans[1] & hready;

   // register decode, bus slave and serial sequencer
   always_comb begin
      logic [1:0] len; // requested byte count
      len   = 2'd0;
      nxt_s = s;
      nxt_s.div = tick ? 8'd0 : s.div + 8'd1;

      // address phase: capture writes, prepare read data; unmapped reads give zero
      nxt_s.wrPend = ahbGo & hwrite;
      if (ahbGo) nxt_s.wrAddr = haddr[7:0];
      if (ahbGo && !hwrite) begin
         unique case (haddr[7:0])
            REG_STAT: nxt_s.rdata = {30'd0, s.nack, s.busy};
            REG_DATA: nxt_s.rdata = s.data;
            default:  nxt_s.rdata = DATA_RST;
         endcase
      end
      // data phase of a command write starts a read unless one is running
      if (s.wrPend && s.wrAddr == REG_CMD && hwdata[CMD_GO] && !s.busy) begin
         len        = hwdata[CMD_LEN_LSB +: 2];
         nxt_s.addr = hwdata[CMD_ADDR_LSB +: 7];
         nxt_s.left = (len == 2'd0) ? 2'd1 : len;
         nxt_s.data = DATA_RST;
         nxt_s.nack = 1'b0;
         nxt_s.busy = 1'b1;
         nxt_s.st   = H_START;
         nxt_s.q    = 2'd0;
         nxt_s.div  = 8'd0;
      end else if (tick) begin
         nxt_s.q = s.q + 2'd1;
         unique case (s.st)
            H_IDLE: nxt_s.q = 2'd0;
            // data falls while clock is high, then clock goes low
            H_START: begin
               if (s.q == 2'd1) nxt_s.sdaLow = 1'b1;
               if (s.q == 2'd3) begin
                  nxt_s.sclLow = 1'b1;
                  nxt_s.st     = H_ADDR;
                  nxt_s.sh     = {s.addr, 1'b1};
                  nxt_s.cnt    = 4'd0;
               end
            end
            // address byte out, then the device acknowledge in
            H_ADDR: begin
               unique case (s.q)
                  2'd0: nxt_s.sdaLow = (s.cnt == 4'd8) ? 1'b0 : ~s.sh[7];
                  2'd1: nxt_s.sclLow = 1'b0;
                  2'd2: if (s.cnt == 4'd8) nxt_s.nack = bus.sda;
                  2'd3: begin
                     nxt_s.sclLow = 1'b1;
                     nxt_s.sh     = {s.sh[6:0], 1'b0};
                     nxt_s.cnt    = s.cnt + 4'd1;
                     if (s.cnt == 4'd8) begin
                        nxt_s.st  = s.nack ? H_STOP : H_DATA;
                        nxt_s.cnt = 4'd0;
                     end
                  end
               endcase
            end
            // byte in, then ack all but the last byte
            H_DATA: begin
               unique case (s.q)
                  2'd0: nxt_s.sdaLow = (s.cnt == 4'd8) && (s.left != 2'd1);
                  2'd1: nxt_s.sclLow = 1'b0;
                  2'd2: if (s.cnt != 4'd8) nxt_s.sh = {s.sh[6:0], bus.sda};
                  2'd3: begin
                     nxt_s.sclLow = 1'b1;
                     nxt_s.cnt    = s.cnt + 4'd1;
                     if (s.cnt == 4'd8) begin
                        nxt_s.data = {s.data[23:0], s.sh};
                        nxt_s.left = s.left - 2'd1;
                        nxt_s.cnt  = 4'd0;
                        if (s.left == 2'd1) nxt_s.st = H_STOP;
                     end
                  end
               endcase
            end
            // data rises while clock is high
            H_STOP: begin
               unique case (s.q)
                  2'd0: nxt_s.sdaLow = 1'b1;
                  2'd1: nxt_s.sclLow = 1'b0;
                  2'd2: nxt_s.sdaLow = 1'b0;
                  2'd3: begin
                     nxt_s.busy = 1'b0;
                     nxt_s.st   = H_IDLE;
                  end
               endcase
            end
            default: nxt_s.st = H_IDLE;
         endcase
      end
   end

   // state register with synchronous reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '0;
         s.rdy <= 1'b1;
      end else begin
         s <= nxt_s;
      end
   end

   assign bus.sclOut  = 1'b0;
   assign bus.sclOe   = s.sclLow;
   assign bus.hSdaOut = 1'b0;
   assign bus.hSdaOe  = s.sdaLow;
   assign hreadyout   = s.rdy;
   assign hresp       = 1'b0;
   assign hrdata      = s.rdata;
endmodule // mrs_host_end
`default_nettype wire

/* test/mrs_chk.sv */
`timescale 1ns/10ps
`default_nettype none
// watches the serial pair and the status byte of the device end
module mrs_chk (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       scl,
   input wire logic       sda,
   input wire logic       dSdaOe,
   input wire logic [7:0] statusByte,
   input wire logic       onCtl,
   input wire logic       software_force_off,
   input wire logic       digTripEvt,
   input wire logic       switchFailEvt,
   input wire logic       switch_fail_enable,
   input wire logic       clearReq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // a clear request with no new digital trip behind it
   sequence s_clear;
      clearReq ##1 !digTripEvt [*3];
   endsequence
   // no clear request lately while the digital alert stands
   sequence s_quiet;
      !clearReq [*4] ##0 statusByte[1];
   endsequence
   a_dev_edge_low: assert property ($changed(dSdaOe) |-> !scl) else $error("device data moved with clock high");
   a_start_by_host: assert property (scl && $past(scl) && $fell(sda) |-> !dSdaOe) else $error("device made a start");
   a_upper_bits_zero: assert property (statusByte[7:6] == 2'b00) else $error("status top bits set");
   a_off_follows: assert property (1 |=> statusByte[4] == $past(!onCtl || software_force_off))
      else $error("off bit wrong");
   a_trip_sets_alert: assert property (digTripEvt |=> ##1 statusByte[1]) else $error("trip not flagged");
   a_fail_sets_flag: assert property (switchFailEvt && switch_fail_enable |=> ##1 statusByte[3])
      else $error("failure not flagged");
   a_clear_drops_alert: assert property (s_clear |=> !statusByte[1]) else $error("clear left alert");
   a_sticky_alert_holds: assert property (s_quiet |=> statusByte[1]) else $error("alert lost");
endmodule // mrs_chk
`default_nettype wire

/* test/monitor_readback_status_port_test.sv */
`timescale 1ns/10ps
`default_nettype none
// both ends joined, host driven over its register bus
module monitor_readback_status_port_test;
   import mrs_pkg::*;
   logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, voltDone = 0, ampDone = 0, voltOnceReq = 0;
   logic voltSelect = 1, ampSelect = 0, statusRead = 0, digTripEvt = 0, switchFailEvt = 0;
   logic onCtl = 1, software_force_off = 0, clearReq = 0, hreadyout, hresp;
   logic ampOver = 0, ampOnceReq = 0, offAlertEnable = 1, switch_fail_enable = 1;
   logic voltOncePend, ampOncePend, clearBusy;
   logic [1:0]  htrans = 0;
   logic [11:0] voltCode = 0, ampCode = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
   logic [7:0]  statusByte;
   int fails = 0, cmp_count = 0;
   mrs_i2c_if bus();
   mrs_dev_end u_mrs_dev_end (.clk(clk), .rst_n(rst_n), .bus(bus), .devAddr(7'h2A), .voltCode(voltCode),
      .voltDone(voltDone), .ampCode(ampCode), .ampDone(ampDone), .ampOver(ampOver), .voltSelect(voltSelect),
      .ampSelect(ampSelect), .voltOnceReq(voltOnceReq), .ampOnceReq(ampOnceReq), .statusRead(statusRead),
      .digTripEvt(digTripEvt), .analog_trip_off_state(1'b0), .switchFailEvt(switchFailEvt),
      .switch_fail_enable(switch_fail_enable), .offAlertEnable(offAlertEnable), .onCtl(onCtl),
      .software_force_off(software_force_off), .clearReq(clearReq), .statusByte(statusByte),
      .voltOncePend(voltOncePend), .ampOncePend(ampOncePend), .clearBusy(clearBusy));
   mrs_host_end #(.QTR(4)) u_mrs_host_end (.clk(clk), .rst_n(rst_n), .bus(bus), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
   mrs_chk u_mrs_chk (.clk(clk), .rst_n(rst_n), .scl(bus.scl), .sda(bus.sda), .dSdaOe(bus.dSdaOe),
      .statusByte(statusByte), .onCtl(onCtl), .software_force_off(software_force_off), .digTripEvt(digTripEvt),
      .switchFailEvt(switchFailEvt), .switch_fail_enable(switch_fail_enable), .clearReq(clearReq));
   // 125 MHz clock
   always #4 clk = ~clk;
   // compare and count
   task chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   // one single word transfer, address then data phase
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk); hsel <= 1; haddr <= a; htrans <= 2'b10; hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 0; htrans <= 2'b00; hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   // one read of len bytes, then judge acknowledge and data
   task xfer(input logic [1:0] len, input logic [31:0] e, input logic nak);
      ahb(1, 32'(REG_CMD), 32'h0001_0000 | (32'(len) << CMD_LEN_LSB) | 32'h0000_002A);
      repeat (400) begin
         ahb(0, 32'(REG_STAT), 0);
         if (q[STAT_BUSY] === 1'b0) break;
      end
      chk(32'(q[STAT_BUSY+:2]), 32'({nak, 1'b0}));
      ahb(0, 32'(REG_DATA), 0);
      if (!nak) chk(q, e);
   endtask
   // one conversion of each channel, as a one-cycle done pulse
   task conv(input logic [11:0] v, input logic [11:0] a);
      @(posedge clk); voltCode <= v; ampCode <= a; voltDone <= 1; ampDone <= 1;
      @(posedge clk); voltDone <= 0; ampDone <= 0;
   endtask
   task t_zero; xfer(2, 0, 0); endtask
   task t_modes;
      conv(12'hA5C, 12'h3B7);
      ampSelect <= 1; xfer(3, 32'h00A5_3BC7, 0);
      ampSelect <= 0; xfer(2, 32'h0000_A5C0, 0);
      voltSelect <= 0; ampSelect <= 1; xfer(2, 32'h0000_3B70, 0);
   endtask
   task t_once;
      @(posedge clk); voltSelect <= 1; ampSelect <= 0; voltOnceReq <= 1;
      @(posedge clk); voltOnceReq <= 0;
      @(negedge clk); chk(32'(voltOncePend), 1);
      xfer(2, 0, 1);
      conv(12'h123, 12'h000); xfer(2, 32'h0000_1230, 0);
      @(posedge clk); voltSelect <= 0; ampSelect <= 1; ampOnceReq <= 1;
      @(posedge clk); ampOnceReq <= 0;
      @(negedge clk); chk(32'(ampOncePend), 1);
      xfer(2, 0, 1);
      conv(12'h000, 12'h456); xfer(2, 32'h0000_4560, 0);
   endtask
   task t_status;
      @(posedge clk); ampOver <= 1;
      repeat (3) conv(12'h000, 12'h000);
      @(posedge clk); statusRead <= 1; digTripEvt <= 1; switchFailEvt <= 1; onCtl <= 0;
      @(posedge clk); digTripEvt <= 0; switchFailEvt <= 0;
      xfer(1, 32'h0000_003F, 0);
      @(posedge clk); clearReq <= 1; onCtl <= 1; software_force_off <= 1; ampOver <= 0;
      @(posedge clk); clearReq <= 0;
      @(negedge clk); chk(32'(clearBusy), 1);
      @(negedge clk); chk(32'(clearBusy), 0);
      conv(12'h000, 12'h000); xfer(1, 32'h0000_0010, 0);
   endtask
   // verdict and end of run
   task conclude;
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1;
      t_zero; t_modes; t_once; t_status;
      conclude;
   end
   // cut a hang short
   initial begin
      #400_000;
      fails++;
      conclude;
   end
endmodule // monitor_readback_status_port_test
`default_nettype wire
